// file: tb/sbw_ctrl_model.sv
// controller model: pin clocks, write port and read port of the sram port
// assumes sys_clk from the bench; one call of cyc is one pin clock period of 16 cycles
`timescale 1ns/1ps
module sbw_ctrl_model (
  // system
  input wire logic sys_clk,
  // clocks
  output logic posInClk,
  output logic negInClk,
  output logic posOutClk,
  output logic negOutClk,
  // ports
  output logic writePortSelectN,
  output logic readPortSelectN,
  output logic [sbw_pkg::LANES-1:0] byteLaneWriteSelectN,
  output logic [sbw_pkg::DATA_W-1:0] writeData,
  output logic [7:0] addrIn
);
  import sbw_pkg::*;
  logic tieOut;
  initial begin
    tieOut = 1'b0;
    {posInClk, posOutClk, negOutClk} = 3'h0; // output clocks not both high: normal mode
    negInClk = 1'b1;
    {writePortSelectN, readPortSelectN} = 2'h3;
    byteLaneWriteSelectN = 4'hF;
    writeData = '0;
    addrIn = 8'h00;
  end
  // output clocks both high ahead of a reset strap single clock mode, then stay tied
  task automatic strap_high();
    @(posedge sys_clk);
    tieOut <= 1'b1;
    {posOutClk, negOutClk} <= 2'h3;
  endtask
  // clocks stop with the negative pair high between calls; parking all high is optional
  // beat0 and selects, pos rise, beat1, neg rise; out clocks follow in clocks unless strap_high has tied them high
  task automatic cyc(input logic write_port_select_n, input logic read_port_select_n, input logic [3:0] s0, input logic [35:0] d0,
      input logic [3:0] s1, input logic [35:0] d1, input logic [7:0] a);
    @(posedge sys_clk);
    writePortSelectN <= write_port_select_n;
    readPortSelectN <= read_port_select_n;
    byteLaneWriteSelectN <= s0;
    writeData <= d0;
    addrIn <= a;
    repeat (4) @(posedge sys_clk);
    {posInClk, posOutClk, negInClk, negOutClk} <= {3'h6, tieOut};
    repeat (4) @(posedge sys_clk);
    byteLaneWriteSelectN <= s1;
    writeData <= d1;
    repeat (4) @(posedge sys_clk);
    {posInClk, posOutClk, negInClk, negOutClk} <= {1'b0, tieOut, 2'h3};
    repeat (3) @(posedge sys_clk);
  endtask
endmodule

// file: tb/sbw_port_checker.sv
// checker for the read side and register port of the byte-lane write mask port
// assumes the bench keeps the pin clocks running until a read has ended
`timescale 1ns/1ps
module sbw_port_checker (
  // system
  input wire logic sys_clk,
  input wire logic rst_b,
  // pins
  input wire logic posInClk,
  input wire logic negInClk,
  input wire logic posOutClk,
  input wire logic negOutClk,
  input wire logic readPortSelectN,
  input wire logic [sbw_pkg::DATA_W-1:0] readData,
  input wire logic readDataOeN,
  // register port
  input wire logic regRdEn,
  input wire logic [sbw_pkg::REG_DW-1:0] regRdData
);
  import sbw_pkg::*;
  logic rdSeen_reg;
  logic [3:0] clkPrev_reg;
  logic [2:0] clkQuiet_reg;
  logic [6:0] selQuiet_reg;
  wire logic [3:0] clkNow = {posInClk, negInClk, posOutClk, negOutClk};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) rdSeen_reg <= 1'b0;
    else if (!readPortSelectN) rdSeen_reg <= 1'b1;
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      clkPrev_reg <= 4'h0;
      clkQuiet_reg <= 3'h7;
    end else begin
      clkPrev_reg <= clkNow;
      if (clkPrev_reg != clkNow) clkQuiet_reg <= 3'h0;
      else if (clkQuiet_reg != 3'h7) clkQuiet_reg <= clkQuiet_reg + 3'h1;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) selQuiet_reg <= 7'h00;
    else if (!readPortSelectN) selQuiet_reg <= 7'h00;
    else if (selQuiet_reg != 7'h7F) selQuiet_reg <= selQuiet_reg + 7'h01;
  end
  sequence oeLowRun;
    !readDataOeN [*7];
  endsequence
  sequence oeEnds;
    ##[8:40] $rose(readDataOeN);
  endsequence
  a_oe_before_read: assert property (!rdSeen_reg |-> readDataOeN)
    else $error("read data enabled before any read");
  a_data_quiet: assert property (!rdSeen_reg |-> readData == '0)
    else $error("read data moved before any read");
  a_data_near_clk: assert property (!$stable(readData) |-> clkQuiet_reg < 3'h6)
    else $error("read data changed away from a clock rise");
  a_oe_fall_clk: assert property ($fell(readDataOeN) |-> clkQuiet_reg < 3'h6)
    else $error("read enable fell away from a clock rise");
  a_oe_held_word: assert property ($fell(readDataOeN) |=> oeLowRun)
    else $error("read enable dropped inside the burst");
  a_oe_ends_bound: assert property ($fell(readDataOeN) |-> oeEnds)
    else $error("read burst did not end in time");
  a_oe_idle_desel: assert property (selQuiet_reg == 7'h7F |-> readDataOeN)
    else $error("read data driven while deselected");
  a_regdata_idle: assert property (!regRdEn |=> regRdData == '0)
    else $error("register read data outside its cycle");
endmodule
bind sbw_write_mask_port sbw_port_checker i_chk (.sys_clk, .rst_b, .posInClk, .negInClk, .posOutClk, .negOutClk,
  .readPortSelectN, .readData, .readDataOeN, .regRdEn, .regRdData);

// file: tb/tb.sv
// bench: writes through the controller model, checks the array via the peek registers
// assumes the checker binds itself from its own file
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb;
  import sbw_pkg::*;
  logic sys_clk, rst_b, regWrEn, regRdEn, rdPend;
  logic posInClk, negInClk, posOutClk, negOutClk, writePortSelectN, readPortSelectN, readDataOeN;
  logic [3:0] byteLaneWriteSelectN, act;
  logic [35:0] writeData, readData, mem [256];
  logic [7:0] addrIn, regAddr;
  logic [31:0] regWrData, regRdData, e;
  logic [31:0] expQ[$];
  logic [35:0] rdQ[$];
  logic [35:0] rdLast, rdExp;
  logic rdOeLast;
  int fail_count, n_checks, wrCnt;
  sbw_write_mask_port i_dut (.sys_clk, .rst_b, .posInClk, .negInClk, .posOutClk, .negOutClk, .writePortSelectN,
    .byteLaneWriteSelectN, .writeData, .addrIn, .readPortSelectN, .readData, .readDataOeN, .regAddr, .regWrData,
    .regWrEn, .regRdEn, .regRdData);
  sbw_ctrl_model i_ctrl (.sys_clk, .posInClk, .negInClk, .posOutClk, .negOutClk, .writePortSelectN,
    .readPortSelectN, .byteLaneWriteSelectN, .writeData, .addrIn);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic summarize();
    if (expQ.size() != 0 || rdQ.size() != 0) fail_count++;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge sys_clk) rdPend <= regRdEn;
  always @(negedge sys_clk) begin
    if (rdPend) begin
      e = expQ.pop_front();
      `CHK("regRdData", e, regRdData)
    end
  end
  // each new word on the read port while it drives takes the oldest expected word
  always @(negedge sys_clk) begin
    if (!readDataOeN && (rdOeLast || readData !== rdLast)) begin
      rdExp = (rdQ.size() > 0) ? rdQ.pop_front() : {36{1'bx}};
      `CHK("readData", rdExp, readData)
    end
    rdOeLast = readDataOeN;
    rdLast = readData;
  end
  task automatic rd(input logic [7:0] a);
    rdQ.push_back(mem[a]);
    rdQ.push_back(mem[a + 8'h01]);
    i_ctrl.cyc(1'b1, 1'b0, 4'hF, 36'($urandom()), 4'hF, 36'($urandom()), a);
    repeat (5) i_ctrl.cyc(1'b1, 1'b1, 4'hF, 36'($urandom()), 4'hF, 36'($urandom()), 8'($urandom()));
  endtask
  task automatic rw(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask
  task automatic rr(input logic [7:0] a, input logic [31:0] x);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    expQ.push_back(x);
    @(posedge sys_clk);
    regRdEn <= 1'b0;
  endtask
  function automatic logic [35:0] mrg(input logic [35:0] o, input logic [35:0] n, input logic [3:0] s);
    for (int i = 0; i < 4; i++) if (!s[i] && act[i]) o[i*9 +: 9] = n[i*9 +: 9];
    return o;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [3:0] s0, input logic [3:0] s1);
    logic [35:0] d0, d1;
    logic [7:0] b;
    d0 = 36'({$urandom(), $urandom()});
    d1 = 36'({$urandom(), $urandom()});
    b = a + 8'h01;
    i_ctrl.cyc(1'b0, 1'b1, s0, d0, s1, d1, a);
    mem[a] = mrg(mem[a], d0, s0);
    mem[b] = mrg(mem[b], d1, s1);
    wrCnt++;
    rw(OFS_PEEKADDR, {24'h0, a});
    rr(OFS_PEEKDATA, mem[a][31:0]);
    rw(OFS_PEEKADDR, {24'h0, b});
    rr(OFS_PEEKDATA, mem[b][31:0]);
  endtask
  task automatic mode(input logic [1:0] m, input logic [3:0] en);
    rw(OFS_CFG, {30'h0, m});
    act = en;
    rr(OFS_CFG, {30'h0, m});
  endtask
  initial begin
    rst_b = 1'b0;
    {regWrEn, regRdEn, rdPend} = 3'h0;
    regAddr = 8'h00;
    regWrData = 32'h0;
    rdOeLast = 1'b1;
    rdLast = '0;
    wrCnt = 0;
    act = LANE_EN_X36;
    void'($urandom(51));
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (12) @(posedge sys_clk);
    rr(OFS_CFG, 32'h2);
    rr(OFS_STATUS, 32'h8);
    rr(8'h40, 32'h0);
    wr(8'hFF, 4'h0, 4'h0);
    wr(8'h10, 4'h0, 4'h0);
    for (int i = 0; i < 4; i++) wr(8'h10, ~(4'h1 << i), ~(4'h8 >> i));
    wr(8'hFF, 4'hF, 4'hF);
    mode(MODE_X18, LANE_EN_X18);
    for (int i = 0; i < 4; i++) wr(8'h10, i[3:0], 4'(3 - i));
    mode(MODE_X9, LANE_EN_X9);
    wr(8'h10, 4'h0, 4'hF);
    wr(8'h11, 4'hE, 4'h1);
    rr(OFS_WRCOUNT, 32'(wrCnt));
    rr(OFS_LASTADDR, 32'h11);
    rd(8'h10);
    rr(OFS_STATUS, 32'h8);
    i_ctrl.strap_high();
    rst_b <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    act = LANE_EN_X36;
    repeat (12) @(posedge sys_clk);
    rr(OFS_CFG, 32'h2);
    rr(OFS_STATUS, 32'h9);
    mode(2'h3, LANE_EN_X36);
    wr(8'h20, 4'h0, 4'h0);
    rr(OFS_WRCOUNT, 32'h1);
    rd(8'h20);
    summarize();
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    fail_count++;
    summarize();
  end
endmodule

// file: verilog/sbw_lane_merge.sv
// lane merge: builds the word to store from the old word, the new beat and its selects
// assumes active-low selects, already synchronised to the system clock
`timescale 1ns/1ps
module sbw_lane_merge #(
  parameter int LANES = sbw_pkg::LANES,
  parameter int LANE_W = sbw_pkg::LANE_W
) (
  // stored and incoming words
  input wire logic [LANES*LANE_W-1:0] oldWord,
  input wire logic [LANES*LANE_W-1:0] newWord,
  // per-lane selects and lanes present in this width
  input wire logic [LANES-1:0] selN,
  input wire logic [LANES-1:0] laneActive,
  // word to store
  output logic [LANES*LANE_W-1:0] mergedWord
);
  import sbw_pkg::*;

  genvar i;
  generate
    for (i = 0; i < LANES; i++) begin : g_lane
      // a lane updates only when its select is low and it exists in this width
      assign mergedWord[i*LANE_W +: LANE_W] = (!selN[i] && laneActive[i]) ?
        newWord[i*LANE_W +: LANE_W] : oldWord[i*LANE_W +: LANE_W];
    end
  endgenerate
endmodule

// file: verilog/sbw_pkg.sv
// package for the byte-lane write mask port: widths, register map, modes, states
// assumes a 32-bit plain register port and a single system clock
package sbw_pkg;
  // lane and data geometry
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int DATA_W = 36;
  localparam int ADDR_W_DEF = 8;
  localparam int REG_AW = 8;
  localparam int REG_DW = 32;
  localparam int CNT_W = 16;

  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_WRCOUNT = 8'h08;
  localparam logic [7:0] OFS_LASTADDR = 8'h0C;
  localparam logic [7:0] OFS_PEEKADDR = 8'h10;
  localparam logic [7:0] OFS_PEEKDATA = 8'h14;

  // width configuration field in the config register, bits [1:0]
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_MODE_W = 2;
  localparam logic [1:0] MODE_X9 = 2'h0;
  localparam logic [1:0] MODE_X18 = 2'h1;
  localparam logic [1:0] MODE_X36 = 2'h2;
  localparam logic [1:0] CFG_MODE_RESET = 2'h2;

  // lanes that exist in each width configuration
  localparam logic [3:0] LANE_EN_X9 = 4'h1;
  localparam logic [3:0] LANE_EN_X18 = 4'h3;
  localparam logic [3:0] LANE_EN_X36 = 4'hF;

  // status bit positions
  localparam int ST_SINGLE_CLK = 0;
  localparam int ST_WR_PENDING = 1;
  localparam int ST_RD_DRIVING = 2;
  localparam int ST_STRAP_DONE = 3;

  // system clock and strap capture
  localparam int CLK_PERIOD_NS = 50;
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // read port states, one-hot
  typedef enum logic [4:0] {
    RD_IDLE = 5'h01,
    RD_ARMED = 5'h02,
    RD_WAITC = 5'h04,
    RD_BEAT0 = 5'h08,
    RD_BEAT1 = 5'h10
  } sbw_rd_state_e;
endpackage

// file: verilog/sbw_write_mask_port.sv
// burst-of-two double-data-rate sram port with byte-lane write masking
// assumes all pins are asynchronous to sys_clk and held steady for at least 3 cycles around each clock edge
// Notes on behaviour
// - x18, both selects low: all eighteen bits of the beat are written
// - x18, select0 low only: bits 8..0 written, 17..9 kept
// - x18, select1 low only: bits 17..9 written, 8..0 kept
// - x18, both selects high: stored word left untouched
// - x9, select low: bits 8..0 of the beat written
// - x9 and x36, all selects high: no update for that beat
// - x36, all four selects low: all thirty-six bits written
// - x36, select0 low only: bits 8..0 written, 35..9 kept
// - x36, select1 low only: bits 17..9 written, rest kept
// - x36, select2 low only: bits 26..18 written, rest kept
// - x36, select3 low only: bits 35..27 written, rest kept
// - selects sampled separately on positive and negative clock beats
// - after power-up both ports idle and read data not driven
// - first burst location is latched address, second is address plus one
// - write data taken on both input clock rises; read data on output clock rises, or on input clock rises in single clock mode
// - write starts at positive rise with select low; address and beat two at negative rise
`timescale 1ns/1ps
module sbw_write_mask_port #(
  parameter int ADDR_W = sbw_pkg::ADDR_W_DEF
) (
  // system
  input wire logic sys_clk,
  input wire logic rst_b,
  // input and output clocks from the controller
  input wire logic posInClk,
  input wire logic negInClk,
  input wire logic posOutClk,
  input wire logic negOutClk,
  // write port
  input wire logic writePortSelectN,
  input wire logic [sbw_pkg::LANES-1:0] byteLaneWriteSelectN,
  input wire logic [sbw_pkg::DATA_W-1:0] writeData,
  input wire logic [ADDR_W-1:0] addrIn,
  // read port
  input wire logic readPortSelectN,
  output logic [sbw_pkg::DATA_W-1:0] readData,
  output logic readDataOeN,
  // register port
  input wire logic [sbw_pkg::REG_AW-1:0] regAddr,
  input wire logic [sbw_pkg::REG_DW-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [sbw_pkg::REG_DW-1:0] regRdData
);
  import sbw_pkg::*;

  localparam int PIN_W = 6 + LANES + DATA_W + ADDR_W;

  logic rstMeta_reg;
  logic rstN;
  logic [PIN_W-1:0] pinRaw;
  logic [PIN_W-1:0] pinMeta_reg;
  logic [PIN_W-1:0] pinSync_reg;
  logic [3:0] clkLast_reg;
  logic kS, knS, cS, cnS, wpsS, rpsS;
  logic [LANES-1:0] bwsS;
  logic [DATA_W-1:0] dataS;
  logic [ADDR_W-1:0] addrS;
  logic [ADDR_W-1:0] addrPlus1;
  logic kRise, knRise, cRise, cnRise;
  logic posLaunch, negLaunch;
  logic [1:0] strapCnt_reg;
  logic strapDone_reg;
  logic singleClk_reg;
  logic [1:0] cfgMode_reg;
  logic [LANES-1:0] laneActive;
  logic wrPend_reg;
  logic [DATA_W-1:0] beat0Data_reg;
  logic [LANES-1:0] beat0Sel_reg;
  logic wrStart, wrFinish;
  logic [DATA_W-1:0] merged0, merged1;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [CNT_W-1:0] wrCount_reg;
  logic [ADDR_W-1:0] lastAddr_reg;
  logic [ADDR_W-1:0] peekAddr_reg;
  sbw_rd_state_e rdState_reg;
  logic [ADDR_W-1:0] rdAddr_reg;
  logic rdStart;
  logic [REG_DW-1:0] regRdData_next;

  // reset release through two flip-flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_reg <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstN <= rstMeta_reg;
    end
  end

  // every pin passes two flip-flops; clocks and data share the same latency
  assign pinRaw = {posInClk, negInClk, posOutClk, negOutClk, writePortSelectN, readPortSelectN,
                   byteLaneWriteSelectN, writeData, addrIn};

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      pinMeta_reg <= '1;
      pinSync_reg <= '1;
    end else begin
      pinMeta_reg <= pinRaw;
      pinSync_reg <= pinMeta_reg;
    end
  end

  assign {kS, knS, cS, cnS, wpsS, rpsS, bwsS, dataS, addrS} = pinSync_reg;

  // edge detection on the synchronised clocks
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      clkLast_reg <= 4'hF;
    end else begin
      clkLast_reg <= {kS, knS, cS, cnS};
    end
  end

  assign kRise = kS & ~clkLast_reg[3];
  assign knRise = knS & ~clkLast_reg[2];
  assign cRise = cS & ~clkLast_reg[1];
  assign cnRise = cnS & ~clkLast_reg[0];

  // strap capture once the synchronisers are filled after reset
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      strapCnt_reg <= 2'h0;
      strapDone_reg <= 1'b0;
      singleClk_reg <= 1'b0;
    end else if (!strapDone_reg) begin
      if (strapCnt_reg == STRAP_WAIT) begin
        singleClk_reg <= cS & cnS;
        strapDone_reg <= 1'b1;
      end else begin
        strapCnt_reg <= strapCnt_reg + 2'h1;
      end
    end
  end

  // launch edges follow the output clocks, or the input clocks in single clock mode
  assign posLaunch = singleClk_reg ? kRise : cRise;
  assign negLaunch = singleClk_reg ? knRise : cnRise;

  // lanes present in the configured width
  always_comb begin
    if (cfgMode_reg == MODE_X9) begin
      laneActive = LANE_EN_X9;
    end else if (cfgMode_reg == MODE_X18) begin
      laneActive = LANE_EN_X18;
    end else begin
      laneActive = LANE_EN_X36;
    end
  end

  // write sequence: first beat at positive rise, address and second beat at negative rise
  assign wrStart = strapDone_reg & kRise & ~wpsS & ~wrPend_reg;
  assign wrFinish = wrPend_reg & knRise;
  assign addrPlus1 = addrS + {{(ADDR_W-1){1'b0}}, 1'b1};

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      wrPend_reg <= 1'b0;
      beat0Data_reg <= '0;
      beat0Sel_reg <= '1;
    end else if (wrStart) begin
      wrPend_reg <= 1'b1;
      beat0Data_reg <= dataS;
      beat0Sel_reg <= bwsS;
    end else if (wrFinish) begin
      wrPend_reg <= 1'b0;
    end
  end

  sbw_lane_merge #(
    .LANES(LANES),
    .LANE_W(LANE_W)
  ) u_merge0 (
    .oldWord(mem[addrS]),
    .newWord(beat0Data_reg),
    .selN(beat0Sel_reg),
    .laneActive(laneActive),
    .mergedWord(merged0)
  );

  sbw_lane_merge #(
    .LANES(LANES),
    .LANE_W(LANE_W)
  ) u_merge1 (
    .oldWord(mem[addrPlus1]),
    .newWord(dataS),
    .selN(bwsS),
    .laneActive(laneActive),
    .mergedWord(merged1)
  );

  // array update; an all-high beat stores the old word back, so it is a no-op
  always_ff @(posedge sys_clk) begin
    if (wrFinish) begin
      mem[addrS] <= merged0;
      mem[addrPlus1] <= merged1;
    end
  end

  // write bookkeeping for software
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      wrCount_reg <= '0;
      lastAddr_reg <= '0;
    end else if (wrFinish) begin
      wrCount_reg <= wrCount_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      lastAddr_reg <= addrS;
    end
  end

  // read port: request at positive rise, first word at the launch after the next positive rise (at that rise in single clock mode), second at negative launch
  assign rdStart = strapDone_reg & kRise & ~rpsS & (rdState_reg == RD_IDLE);

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      rdState_reg <= RD_IDLE;
      rdAddr_reg <= '0;
    end else begin
      case (rdState_reg)
        RD_IDLE: begin
          if (rdStart) begin
            rdAddr_reg <= addrS;
            rdState_reg <= RD_ARMED;
          end
        end
        RD_ARMED: begin
          if (kRise && singleClk_reg) begin
            rdState_reg <= RD_BEAT0;
          end else if (kRise) begin
            rdState_reg <= RD_WAITC;
          end
        end
        RD_WAITC: begin
          if (posLaunch) begin
            rdState_reg <= RD_BEAT0;
          end
        end
        RD_BEAT0: begin
          if (negLaunch) begin
            rdState_reg <= RD_BEAT1;
          end
        end
        RD_BEAT1: begin
          if (posLaunch) begin
            rdState_reg <= RD_IDLE;
          end
        end
        default: begin
          rdState_reg <= RD_IDLE;
        end
      endcase
    end
  end

  // read data and enable from flip-flops; not driven until a read is issued
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      readData <= '0;
      readDataOeN <= 1'b1;
    end else if (((rdState_reg == RD_ARMED) && kRise && singleClk_reg) ||
                 ((rdState_reg == RD_WAITC) && posLaunch)) begin
      readData <= mem[rdAddr_reg];
      readDataOeN <= 1'b0;
    end else if ((rdState_reg == RD_BEAT0) && negLaunch) begin
      readData <= mem[rdAddr_reg + {{(ADDR_W-1){1'b0}}, 1'b1}];
    end else if ((rdState_reg == RD_BEAT1) && posLaunch) begin
      readDataOeN <= 1'b1;
    end
  end

  // register writes
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      cfgMode_reg <= CFG_MODE_RESET;
      peekAddr_reg <= '0;
    end else if (regWrEn) begin
      if (regAddr == OFS_CFG) begin
        cfgMode_reg <= regWrData[CFG_MODE_LSB +: CFG_MODE_W];
      end else if (regAddr == OFS_PEEKADDR) begin
        peekAddr_reg <= regWrData[ADDR_W-1:0];
      end
    end
  end

  // register read mux; unmapped offsets read zero
  always_comb begin
    regRdData_next = '0;
    if (regAddr == OFS_CFG) begin
      regRdData_next[CFG_MODE_LSB +: CFG_MODE_W] = cfgMode_reg;
    end else if (regAddr == OFS_STATUS) begin
      regRdData_next[ST_SINGLE_CLK] = singleClk_reg;
      regRdData_next[ST_WR_PENDING] = wrPend_reg;
      regRdData_next[ST_RD_DRIVING] = ~readDataOeN;
      regRdData_next[ST_STRAP_DONE] = strapDone_reg;
    end else if (regAddr == OFS_WRCOUNT) begin
      regRdData_next[CNT_W-1:0] = wrCount_reg;
    end else if (regAddr == OFS_LASTADDR) begin
      regRdData_next[ADDR_W-1:0] = lastAddr_reg;
    end else if (regAddr == OFS_PEEKADDR) begin
      regRdData_next[ADDR_W-1:0] = peekAddr_reg;
    end else if (regAddr == OFS_PEEKDATA) begin
      regRdData_next = mem[peekAddr_reg][REG_DW-1:0];
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      regRdData <= '0;
    end else if (regRdEn) begin
      regRdData <= regRdData_next;
    end else begin
      regRdData <= '0;
    end
  end
endmodule
